/* File: sync_serial_rx_and_slave_tx.sv */
// Synchronous serial port: reception, receive FIFO, slave clocking and transmit
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE_01 - Reception starts when single-word or continuous receive enable is set.
// RULE_02 - Data line is sampled on each falling shift clock edge.
// RULE_03 - Single-word enable alone receives one word, then clears itself.
// RULE_04 - Continuous enable receives words back to back until cleared.
// RULE_05 - Both enables set behaves as continuous; single-word setting ignored.
// RULE_06 - Finished word moves to FIFO if room, then receive flag sets.
// RULE_07 - Receive flag is read-only, cleared when reads empty the FIFO.
// RULE_08 - Receive interrupt only when receive flag and its enable are set.
// RULE_09 - Receive FIFO holds two words while a third shifts in.
// RULE_10 - Full FIFO at last bit sets overrun and drops the word.
// RULE_11 - Overrun blocks FIFO loads; cleared by clearing continuous enable.
// RULE_12 - Ninth bit travels with its byte; each read shows next one.
// RULE_13 - Software reads status before data to keep ninth bit and errors.
// RULE_14 - Master receive setup order: divisor, mode bits, options, then enable.
// RULE_15 - Clock-source bit clear selects slave, clock taken from pin.
// RULE_16 - Slave mode keeps shifting on external clock during Sleep.
// RULE_17 - Slave transmit and receive otherwise work exactly as master.
// RULE_18 - Two buffered words: flag clear until second enters shift register.
// RULE_19 - Transmit flag with its enable wakes device from Sleep.
// RULE_20 - Slave transmit setup order: mode bits, options, enable, ninth bit, data.
// RULE_21 - Software sets global and peripheral interrupt enables for delivery.
// RULE_22 - Master mode drives the shift clock onto the clock pin.
// RULE_23 - Baud generator held in reset while all three enables are clear.
// RULE_24 - Master receive leaves data pin released, clock toggles at divisor rate.
module sync_serial_rx_and_slave_tx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sync_serial_pkg::wb_req_type wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic shift_clock_pin_i,
  input wire logic serial_data_pin_i,
  input wire logic sleep_i,
  output sync_serial_pkg::pin_out_type pins_o,
  output logic periph_irq_o,
  output logic core_irq_o,
  output logic wake_o
);
  import sync_serial_pkg::*;

  state_type st;
  state_type nx;
  logic req, wr, rd_rx, wr_receive_status_control, sync_on, brg_run, rx_mode, tx_mode;
  logic sel_ck, ck_rise, ck_fall, word_done, rx_flag, tx_flag, periph;
  logic [3:0] rx_bits, tx_bits;
  logic [7:0] wd, rd_data;
  logic [8:0] word;

  assign req = wb_i.cyc && wb_i.stb && !st.ack;
  assign wr = req && wb_i.we && wb_i.sel[0];
  assign wd = wb_i.dat[7:0];
  assign rd_rx = req && !wb_i.we && (wb_i.adr[9:2] == idx_receive_buffer);
  assign wr_receive_status_control = wr && (wb_i.adr[9:2] == idx_receive_status_control);
  assign sync_on = st.serial_port_enable && st.sync;
  assign brg_run = st.tx_enable || st.continuous_rx_enable || st.single_word_rx_enable;
  assign rx_mode = sync_on && (st.continuous_rx_enable || st.single_word_rx_enable); // [RULE_01]
  assign tx_mode = sync_on && st.tx_enable && !rx_mode;
  assign sel_ck = st.clock_source_master ? st.ck_int : shift_clock_pin_i; // [RULE_15] [RULE_16]
  assign ck_rise = sel_ck && !st.ck_prev;
  assign ck_fall = !sel_ck && st.ck_prev;
  assign rx_bits = st.rx9 ? bits_nine : bits_eight;
  assign tx_bits = st.tx9 ? bits_nine : bits_eight;
  assign word_done = rx_mode && ck_fall && (st.rx_cnt == rx_bits - 4'h1);
  assign rx_flag = st.fifo_cnt != fifo_empty;
  assign tx_flag = !st.transmit_buffer_full;
  assign periph = (rx_flag && st.pie[bit_rx_irq_enable]) || (tx_flag && st.pie[bit_tx_irq_enable]);

  always_comb begin
    nx = st;
    word = st.rx_shift_register;
    word[st.rx_cnt] = serial_data_pin_i;
    rd_data = 8'h00;
    nx.ack = req;
    case (wb_i.adr[9:2])
      idx_interrupt_control: rd_data = st.interrupt_control;
      idx_peripheral_flags_one: begin
        rd_data[bit_rx_flag] = rx_flag;
        rd_data[bit_tx_flag] = tx_flag;
      end
      idx_receive_status_control: rd_data = {st.serial_port_enable, st.rx9, st.single_word_rx_enable, st.continuous_rx_enable, 2'h0, st.overrun_error, st.fifo[0][8]};
      idx_transmit_buffer: rd_data = st.transmit_buffer;
      idx_receive_buffer: rd_data = st.fifo[0][7:0];
      idx_peripheral_enables_one: rd_data = st.pie;
      idx_transmit_status_control: rd_data = {st.clock_source_master, st.tx9, st.tx_enable, st.sync, 1'h0, st.brgh, !st.tsr_full, st.tx_ninth_bit};
      idx_baud_divisor: rd_data = st.brg_val;
      default: rd_data = 8'h00;
    endcase
    nx.dat = (req && !wb_i.we) ? rd_data : 8'h00;

    // Single word ends the enable; continuous keeps it
    if (word_done && !st.continuous_rx_enable) begin
      nx.single_word_rx_enable = 1'b0; // [RULE_03] [RULE_04] [RULE_05]
    end

    // Transmitter, before bus writes so a fresh buffer write is kept
    if (!st.tx_enable) begin
      nx.tsr_full = 1'b0;
      nx.tx_cnt = 4'h0;
    end else if (tx_mode) begin
      if (!st.tsr_full && st.transmit_buffer_full) begin
        nx.tx_shift_register = {st.tx_ninth_bit, st.transmit_buffer}; // [RULE_18]
        nx.tsr_full = 1'b1;
        nx.tx_cnt = 4'h0;
        nx.transmit_buffer_full = 1'b0;
      end else if (st.tsr_full && ck_rise && (st.tx_cnt != tx_bits)) begin
        nx.pins.dt_o = st.tx_shift_register[st.tx_cnt]; // [RULE_17]
        nx.tx_cnt = st.tx_cnt + 4'h1;
      end else if (st.tsr_full && ck_fall && (st.tx_cnt == tx_bits)) begin
        nx.tsr_full = 1'b0;
      end
    end

    // Register writes
    if (wr) begin
      case (wb_i.adr[9:2])
        idx_interrupt_control: nx.interrupt_control = wd;
        idx_receive_status_control: begin
          nx.serial_port_enable = wd[bit_serial_port_enable];
          nx.rx9 = wd[bit_rx_nine_bit_mode];
          nx.single_word_rx_enable = wd[bit_single_word_rx_enable];
          nx.continuous_rx_enable = wd[bit_continuous_rx_enable];
          if (!wd[bit_continuous_rx_enable]) begin
            nx.overrun_error = 1'b0; // [RULE_11]
          end
        end
        idx_transmit_buffer: begin
          nx.transmit_buffer = wd;
          nx.transmit_buffer_full = 1'b1;
        end
        idx_peripheral_enables_one: nx.pie = wd;
        idx_transmit_status_control: begin
          nx.clock_source_master = wd[bit_clock_source_master];
          nx.tx9 = wd[bit_tx_nine_bit_mode];
          nx.tx_enable = wd[bit_tx_enable];
          nx.sync = wd[bit_sync_mode];
          nx.brgh = wd[bit_high_baud];
          nx.tx_ninth_bit = wd[bit_tx_ninth_bit];
        end
        idx_baud_divisor: nx.brg_val = wd;
        default: ;
      endcase
    end

    // Baud generator and master clock
    if (!brg_run) begin
      nx.brg_cnt = st.brg_val; // [RULE_23]
      nx.ck_int = 1'b0;
    end else if (!sleep_i) begin
      if (st.brg_cnt == 8'h00) begin
        nx.brg_cnt = st.brg_val; // [RULE_24]
        nx.ck_int = !st.ck_int;
      end else begin
        nx.brg_cnt = st.brg_cnt - 8'h01;
      end
    end
    nx.ck_prev = sel_ck;

    // Receive shifter
    if (!rx_mode) begin
      nx.rx_cnt = 4'h0;
    end else if (ck_fall) begin
      nx.rx_shift_register = word; // [RULE_02]
      nx.rx_cnt = word_done ? 4'h0 : st.rx_cnt + 4'h1;
    end

    // Receive FIFO: read first, then load or overrun
    if (rd_rx && rx_flag) begin
      nx.fifo[0] = st.fifo[1]; // [RULE_12] [RULE_07]
      nx.fifo_cnt = st.fifo_cnt - 2'h1;
    end
    if (word_done && !st.overrun_error) begin // [RULE_11]
      if (nx.fifo_cnt == fifo_full) begin
        nx.overrun_error = 1'b1; // [RULE_10]
      end else begin
        nx.fifo[nx.fifo_cnt[0]] = {st.rx9 && word[8], word[7:0]}; // [RULE_06] [RULE_09]
        nx.fifo_cnt = nx.fifo_cnt + 2'h1;
      end
    end

    // Pins and interrupt lines
    nx.pins.ck_o = nx.ck_int;
    nx.pins.ck_oe = sync_on && st.clock_source_master && brg_run; // [RULE_22]
    nx.pins.dt_oe = tx_mode && st.tsr_full; // [RULE_24]
    nx.periph_irq = periph; // [RULE_08]
    nx.core_irq = periph && st.interrupt_control[bit_global_irq_enable] && st.interrupt_control[bit_peripheral_irq_enable];
    nx.wake = periph && sleep_i; // [RULE_19]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign wb_dat_o = {24'h000000, st.dat};
  assign wb_ack_o = st.ack;
  assign pins_o = st.pins;
  assign periph_irq_o = st.periph_irq;
  assign core_irq_o = st.core_irq;
  assign wake_o = st.wake;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_single_word_rx_enable_clear: assert property ((word_done && !st.continuous_rx_enable && !wr_receive_status_control) |=> !st.single_word_rx_enable) // [RULE_03]
    else $error("single word enable not cleared");
  a_continuous_rx_enable_wins: assert property ((word_done && st.continuous_rx_enable && !wr_receive_status_control) |=> st.single_word_rx_enable == $past(st.single_word_rx_enable)) // [RULE_05]
    else $error("single word enable changed in continuous mode");
  a_push_flag: assert property ((word_done && st.fifo_cnt == fifo_empty && !st.overrun_error) |=> rx_flag) // [RULE_06]
    else $error("receive flag not set after load");
  a_flag_fall: assert property ($fell(rx_flag) |-> $past(rd_rx)) // [RULE_07]
    else $error("receive flag cleared without read");
  a_irq_gate: assert property (st.periph_irq |-> $past(periph)) // [RULE_08]
    else $error("interrupt without flag and enable");
  a_fifo_max: assert property (st.fifo_cnt <= fifo_full) // [RULE_09]
    else $error("receive fifo over two entries");
  a_ovr_set: assert property ((word_done && !st.overrun_error && st.fifo_cnt == fifo_full && !rd_rx) |=> st.overrun_error) // [RULE_10]
    else $error("overrun not flagged");
  a_ovr_block: assert property ((st.overrun_error && word_done && !rd_rx) |=> $stable(st.fifo_cnt)) // [RULE_11]
    else $error("load while overrun set");
  a_ck_drive: assert property (st.pins.ck_oe |-> $past(st.clock_source_master)) // [RULE_22]
    else $error("clock driven in slave mode");
  a_brg_hold: assert property ((!st.tx_enable && !st.continuous_rx_enable && !st.single_word_rx_enable) |=> !st.ck_int) // [RULE_23]
    else $error("baud generator not held");
  a_dt_hiz: assert property (rx_mode |=> !st.pins.dt_oe) // [RULE_24]
    else $error("data pin driven while receiving");
  a_rx_idle: assert property (!rx_mode |=> st.rx_cnt == 4'h0) // [RULE_01]
    else $error("receive counter runs without enable");
  a_irq_off: assert property ((!st.pie[bit_rx_irq_enable] && !st.pie[bit_tx_irq_enable]) |=> !st.periph_irq) // [RULE_08]
    else $error("interrupt with both enables clear");
  a_ninth_pop: assert property ((rd_rx && st.fifo_cnt == fifo_full) |=> st.fifo[0] == $past(st.fifo[1])) // [RULE_12]
    else $error("next entry not shown after read");
  a_slave_ck: assert property (!st.clock_source_master |=> !st.pins.ck_oe) // [RULE_15]
    else $error("clock pin driven in slave mode");
  a_tx_held: assert property ((st.tsr_full && st.transmit_buffer_full) |=> !tx_flag) // [RULE_18]
    else $error("transmit flag set while both buffers full");
  a_wake_gate: assert property (wake_o |-> $past(sleep_i)) // [RULE_19]
    else $error("wake outside sleep");
endmodule : sync_serial_rx_and_slave_tx
`default_nettype wire

/* File: sync_serial_pkg.sv */
// Constants and types for the synchronous serial receiver and slave transmitter
`default_nettype none
package sync_serial_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] idx_interrupt_control = 8'h0b;
  localparam logic [7:0] idx_peripheral_flags_one = 8'h0c;
  localparam logic [7:0] idx_receive_status_control = 8'h18;
  localparam logic [7:0] idx_transmit_buffer = 8'h19;
  localparam logic [7:0] idx_receive_buffer = 8'h1a;
  localparam logic [7:0] idx_peripheral_enables_one = 8'h8c;
  localparam logic [7:0] idx_transmit_status_control = 8'h98;
  localparam logic [7:0] idx_baud_divisor = 8'h99;
  // Field positions
  localparam int bit_global_irq_enable = 7;
  localparam int bit_peripheral_irq_enable = 6;
  localparam int bit_rx_flag = 5;
  localparam int bit_tx_flag = 4;
  localparam int bit_rx_irq_enable = 5;
  localparam int bit_tx_irq_enable = 4;
  localparam int bit_serial_port_enable = 7;
  localparam int bit_rx_nine_bit_mode = 6;
  localparam int bit_single_word_rx_enable = 5;
  localparam int bit_continuous_rx_enable = 4;
  localparam int bit_clock_source_master = 7;
  localparam int bit_tx_nine_bit_mode = 6;
  localparam int bit_tx_enable = 5;
  localparam int bit_sync_mode = 4;
  localparam int bit_high_baud = 2;
  localparam int bit_tx_ninth_bit = 0;
  // Word lengths and FIFO levels
  localparam logic [3:0] bits_eight = 4'h8;
  localparam logic [3:0] bits_nine = 4'h9;
  localparam int fifo_depth = 2;
  localparam logic [1:0] fifo_empty = 2'h0;
  localparam logic [1:0] fifo_full = 2'h2;
  localparam logic [12:0] irq_vector = 13'h0004;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ck_o;
    logic ck_oe;
    logic dt_o;
    logic dt_oe;
  } pin_out_type;

  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] pie;
    logic serial_port_enable, rx9, single_word_rx_enable, continuous_rx_enable, overrun_error;
    logic clock_source_master, tx9, tx_enable, sync, brgh, tx_ninth_bit;
    logic [7:0] brg_val;
    logic [7:0] brg_cnt;
    logic ck_int, ck_prev;
    logic [7:0] transmit_buffer;
    logic transmit_buffer_full;
    logic [8:0] tx_shift_register;
    logic tsr_full;
    logic [3:0] tx_cnt;
    logic [8:0] rx_shift_register;
    logic [3:0] rx_cnt;
    logic [fifo_depth-1:0][8:0] fifo;
    logic [1:0] fifo_cnt;
    logic ack;
    logic [7:0] dat;
    pin_out_type pins;
    logic periph_irq, core_irq, wake;
  } state_type;
endpackage : sync_serial_pkg
`default_nettype wire

/* File: serial_peer_model.sv */
// Peer device model driving shift clock and data lines
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
  input wire logic clk_i,
  input wire logic ck_i,
  input wire logic dt_i,
  output logic ck_o,
  output logic dt_o
);
  logic [8:0] q[$];
  logic [8:0] cur = 9'h000;
  logic [3:0] idx = 4'h0;
  logic [1:0] div = 2'h0;
  logic run = 1'b0;
  logic ck_d = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] got = 8'h00;
  logic [2:0] nb = 3'h0;
  initial ck_o = 1'b0;
  initial dt_o = 1'b0;
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    if (run && div == 2'h3) ck_o <= ~ck_o; // Clock only while run
    ck_d <= ck_i;
    if (ck_i && !ck_d) begin // Bit set after rise, held past fall
      if (idx == 4'h0) cur = (q.size() > 0) ? q.pop_front() : ~cur;
      dt_o <= cur[idx];
      idx = (idx == 4'h8) ? 4'h0 : idx + 4'h1;
    end
    if (!ck_i && ck_d) begin // Capture device data on fall
      sh <= {dt_i, sh[7:1]};
      nb <= nb + 3'h1;
      if (nb == 3'h7) got <= {dt_i, sh[7:1]};
    end
  end
endmodule : serial_peer_model
`default_nettype wire

/* File: test_sync_serial_rx_and_slave_tx.sv */
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ns
`default_nettype none
module test_sync_serial_rx_and_slave_tx;
  import sync_serial_pkg::*;
  localparam logic [7:0] rcs = idx_receive_status_control;
  localparam logic [7:0] rbuf = idx_receive_buffer;
  localparam logic [7:0] tcs = idx_transmit_status_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sleep_i = 1'b0;
  wb_req_type wb = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, periph_irq_o, core_irq_o, wake_o, pck, pdt, ck, dt;
  pin_out_type pins_o;
  int errors = 0;
  int compares = 0;
  int seed = 23;
  logic [7:0] r;
  logic [8:0] w[3];
  assign ck = pins_o.ck_oe ? pins_o.ck_o : pck;
  assign dt = pins_o.dt_oe ? pins_o.dt_o : pdt;
  sync_serial_rx_and_slave_tx dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .shift_clock_pin_i(ck), .serial_data_pin_i(dt), .sleep_i(sleep_i),
    .pins_o(pins_o), .periph_irq_o(periph_irq_o), .core_irq_o(core_irq_o), .wake_o(wake_o));
  serial_peer_model peer (.clk_i(clk_i), .ck_i(ck), .dt_i(dt), .ck_o(pck), .dt_o(pdt));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {a, 2'b00}, dat: {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1) errors++;
    r = wb_dat_o[7:0];
    wb <= '0;
  endtask : bus
  task automatic poll(input int b);
    int n;
    n = 0;
    do bus(1'b0, idx_peripheral_flags_one, 8'h00); while (r[b] !== 1'b1 && ++n < 100);
    if (r[b] !== 1'b1) errors++;
  endtask : poll
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (w[i]) w[i] = $random(seed);
    bus(1'b0, tcs, 8'h00);
    chk("transmit status reset", 8'h02, r);
    bus(1'b1, 8'h01, 8'h5a);
    bus(1'b0, 8'h01, 8'h00);
    chk("unmapped", 8'h00, r);
    $display("test registers done");
    bus(1'b1, idx_baud_divisor, 8'h01);
    bus(1'b1, tcs, 8'h90);
    bus(1'b1, idx_peripheral_enables_one, 8'h20);
    bus(1'b1, rcs, 8'hc0);
    peer.q.push_back(w[0]);
    bus(1'b1, rcs, 8'he0);
    repeat (3) @(posedge clk_i);
    chk("pin drive", 8'h02, {6'h0, pins_o.ck_oe, pins_o.dt_oe});
    poll(bit_rx_flag);
    chk("rx irq", 8'h01, {7'h0, periph_irq_o});
    bus(1'b0, rcs, 8'h00);
    chk("single status", {7'h60, w[0][8]}, r);
    bus(1'b0, rbuf, 8'h00);
    chk("single data", w[0][7:0], r);
    bus(1'b0, idx_peripheral_flags_one, 8'h00);
    chk("rx flag", 8'h00, r & 8'h20);
    $display("test single word done");
    foreach (w[i]) peer.q.push_back(w[i]);
    bus(1'b1, rcs, 8'hf0);
    repeat (150) @(posedge clk_i);
    bus(1'b0, rcs, 8'h00);
    chk("overrun status", {7'h79, w[0][8]}, r);
    bus(1'b0, rbuf, 8'h00);
    chk("fifo first", w[0][7:0], r);
    bus(1'b0, rcs, 8'h00);
    chk("next ninth", {7'h00, w[1][8]}, r & 8'h01);
    bus(1'b0, rbuf, 8'h00);
    chk("fifo second", w[1][7:0], r);
    repeat (80) @(posedge clk_i);
    bus(1'b0, idx_peripheral_flags_one, 8'h00);
    chk("blocked", 8'h00, r & 8'h20);
    bus(1'b1, rcs, 8'hc0);
    bus(1'b0, rcs, 8'h00);
    chk("overrun clear", 8'hc0, r & 8'hfe);
    $display("test continuous done");
    peer.idx = 4'h0;
    peer.q.delete();
    bus(1'b1, tcs, 8'h10);
    bus(1'b1, idx_interrupt_control, 8'hc0);
    peer.q.push_back(w[2]);
    bus(1'b1, rcs, 8'hd0);
    sleep_i <= 1'b1;
    peer.run <= 1'b1;
    poll(bit_rx_flag);
    chk("slave wake", 8'h06, {5'h0, wake_o, core_irq_o, pins_o.ck_oe});
    bus(1'b0, rbuf, 8'h00);
    chk("slave data", w[2][7:0], r);
    bus(1'b1, rcs, 8'h80);
    @(posedge clk_i iff (!pck && peer.div != 2'h3));
    peer.run <= 1'b0;
    $display("test slave receive done");
    bus(1'b1, idx_peripheral_enables_one, 8'h10);
    bus(1'b1, tcs, 8'h30);
    bus(1'b1, idx_transmit_buffer, w[0][7:0]);
    bus(1'b1, idx_transmit_buffer, w[1][7:0]);
    bus(1'b0, idx_peripheral_flags_one, 8'h00);
    chk("tx flag held", 8'h00, r & 8'h10);
    peer.nb = 3'h0;
    peer.run <= 1'b1;
    poll(bit_tx_flag);
    chk("tx data", w[0][7:0], peer.got);
    chk("tx wake", 8'h03, {6'h0, wake_o, pins_o.dt_oe});
    $display("test slave transmit done");
    end_of_test();
  end
endmodule : test_sync_serial_rx_and_slave_tx
`default_nettype wire
